/* File: verilog/lss_pkg.sv */
// shared constants, types and correction arithmetic for the sensor link
package lss_pkg;

  // word framing: one start bit, eight data bits lsb first, one stop bit
  localparam logic [2:0] BIT_FIRST  = 3'h0;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic       LINE_IDLE  = 1'b1;  // idle and stop level
  localparam logic       LINE_START = 1'b0;  // start bit level

  // pixel array and zone borders
  localparam logic [6:0] PIX_FIRST   = 7'h00;
  localparam logic [6:0] PIX_LAST    = 7'h65;  // pixel 101
  localparam logic [6:0] ZONE1_FIRST = 7'h22;  // pixel 34
  localparam logic [6:0] ZONE2_FIRST = 7'h44;  // pixel 68
  localparam int         ZONES       = 3;
  localparam logic [1:0] ZONE0       = 2'h0;
  localparam logic [1:0] ZONE1       = 2'h1;
  localparam logic [1:0] ZONE2       = 2'h2;

  // command words
  localparam logic [7:0] CMD_RESET   = 8'h1B;
  localparam logic [7:0] CMD_BEGIN   = 8'h08;
  localparam logic [7:0] CMD_CAPTURE = 8'h10;
  localparam logic [7:0] CMD_READOUT = 8'h02;
  localparam logic [7:0] CMD_CANCEL  = 8'h03;
  localparam logic [7:0] CMD_WR_MASK = 8'hE0;  // upper three bits
  localparam logic [7:0] CMD_WR_BASE = 8'h40;  // low five bits: address

  // register addresses
  localparam logic [4:0] ADDR_Z0_OFS  = 5'h00;
  localparam logic [4:0] ADDR_Z0_GAIN = 5'h01;
  localparam logic [4:0] ADDR_Z1_OFS  = 5'h02;
  localparam logic [4:0] ADDR_Z1_GAIN = 5'h03;
  localparam logic [4:0] ADDR_Z2_OFS  = 5'h04;
  localparam logic [4:0] ADDR_Z2_GAIN = 5'h05;
  localparam logic [4:0] ADDR_MODE    = 5'h1F;

  // reset values
  localparam logic [7:0] OFS_RST  = 8'h00;
  localparam logic [4:0] GAIN_RST = 5'h00;
  localparam logic [3:0] MODE_RST = 4'h0;

  // relative gain per code, unsigned with eight fraction bits
  localparam int         GAIN_FRAC = 8;
  localparam logic [9:0] GAIN_Q8 [32] = '{
    10'h100, 10'h105, 10'h10D, 10'h112, 10'h117, 10'h11F, 10'h126, 10'h12E,
    10'h136, 10'h13D, 10'h145, 10'h14F, 10'h157, 10'h161, 10'h16E, 10'h178,
    10'h185, 10'h192, 10'h19F, 10'h1AE, 10'h1BD, 10'h1CF, 10'h1E1, 10'h1F6,
    10'h20D, 10'h224, 10'h23D, 10'h25A, 10'h27B, 10'h29C, 10'h2C5, 10'h2F1};
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hFF;

  // controller clock divider phases, four system clocks per link clock
  localparam logic [1:0] PH_SAMP = 2'h0;  // sample synchronised output
  localparam logic [1:0] PH_FALL = 2'h1;  // link clock falls
  localparam logic [1:0] PH_RISE = 2'h3;  // link clock rises
  localparam logic [2:0] LRST_RELEASE = 3'h4;  // link clocks in reset
  localparam logic [2:0] LRST_UP      = 3'h7;  // link clocks until ready

  // serial word sequencer states
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP}
    lss_ser_e;

  // zone that a pixel belongs to
  function automatic logic [1:0] zone_of(input logic [6:0] pix);
    zone_of = (pix >= ZONE2_FIRST) ? ZONE2 :
              (pix >= ZONE1_FIRST) ? ZONE1 : ZONE0;  // R02
  endfunction

  // offset code: bit 7 set means negative, growing with the low bits
  function automatic logic signed [9:0] ofs_value(input logic [7:0] code);
    logic signed [9:0] mag;
    mag = $signed({3'h0, code[6:0]});
    ofs_value = code[7] ? -mag : mag;  // R03
  endfunction

  // offset first, then gain, then clamp to the eight bit code range
  function automatic logic [7:0] corrected(input logic [7:0] raw,
                                           input logic [7:0] ofs,
                                           input logic [4:0] gain);
    logic signed [9:0]  sum;
    logic signed [20:0] prod;
    logic signed [12:0] scaled;
    sum    = $signed({2'h0, raw}) + ofs_value(ofs);  // R04
    prod   = sum * $signed({1'b0, GAIN_Q8[gain]});   // R05
    scaled = prod[20:GAIN_FRAC];
    if (scaled[12])
      corrected = CODE_MIN;
    else if (scaled > $signed({5'h00, CODE_MAX}))
      corrected = CODE_MAX;
    else
      corrected = scaled[7:0];  // R14
  endfunction

endpackage

/* File: verilog/lss_link_if.sv */
// three wire serial link plus link reset between controller and sensor
`timescale 1ns/1ps
interface lss_link_if;
  logic sclk;               // link clock, made by the controller
  logic serial_command_in;  // controller to sensor words
  logic serial_pixel_out;   // sensor to controller words
  logic link_rst_n;         // link reset, active low

  // sensor end
  modport dev (
    input  sclk,
    input  serial_command_in,
    input  link_rst_n,
    output serial_pixel_out
  );

  // controller end
  modport ctl (
    output sclk,
    output serial_command_in,
    output link_rst_n,
    input  serial_pixel_out
  );
endinterface

/* File: verilog/lss_frame_rx.sv */
// framed word receiver sampling its line on the rising clock edge
`timescale 1ns/1ps
module lss_frame_rx
  import lss_pkg::*;
(
  // clock and synchronous reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial line, synchronous to clk
  input  wire logic       line,
  // received word
  output logic            word_valid,
  output logic [7:0]      word,
  output logic            frame_err
);
  import lss_pkg::*;

  lss_ser_e   state_reg;  // receiver state
  logic [2:0] bit_reg;    // data bit index
  logic [7:0] shift_reg;  // lsb arrives first
  logic       valid_reg;  // one cycle word pulse
  logic       err_reg;    // one cycle framing error pulse

  // a low stop bit drops the word; a held low line then looks like
  // a fresh start bit, so a break just yields further errors
  always_ff @(posedge clk) begin  // R09
    if (!rst_n) begin
      state_reg <= SER_IDLE;
      bit_reg   <= BIT_FIRST;
      shift_reg <= CODE_MIN;
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
      unique case (state_reg)
        SER_IDLE, SER_START: begin
          if (line == LINE_START) begin  // R20
            state_reg <= SER_DATA;
            bit_reg   <= BIT_FIRST;
          end
        end
        SER_DATA: begin
          shift_reg <= {line, shift_reg[7:1]};  // R20
          bit_reg   <= bit_reg + 3'h1;
          if (bit_reg == BIT_LAST)
            state_reg <= SER_STOP;
        end
        SER_STOP: begin
          state_reg <= SER_IDLE;
          valid_reg <= (line == LINE_IDLE);  // R08
          err_reg   <= (line != LINE_IDLE);
        end
      endcase
    end
  end

  assign word_valid = valid_reg;
  assign word       = shift_reg;
  assign frame_err  = err_reg;
endmodule

/* File: verilog/lss_sensor_dev.sv */
// sensor end: command decode, zone registers, integration and readout
`timescale 1ns/1ps

// Function
// (R01) readout sends all 102 pixels unless cancelled; the code also stops it on a reset command
// (R02) three zones of 34 pixels, own settings
// (R03) offset code high bit means negative
// (R04) offset applied before gain
// (R05) five bit gain code, monotonic gain
// (R06) controller sets offsets before gains
// (R07) controller sends commands on its clock
// (R08) one start bit, one stop bit
// (R09) input sampled on rising clock edge
// (R10) output changes on falling clock edge
// (R11) reset command clears integrators until begin
// (R12) begin command releases integrators, starts integration
// (R13) capture command ends integration, samples pixels
// (R14) readout sends eight bit code per pixel
// (R15) controller order: reset, begin, capture, readout
// (R16) all pixels share one integration period
// (R17) offsets at addresses 0, 2, 4
// (R18) gains at addresses 1, 3, 5
// (R19) controller writes zero to mode register
// (R20) idle high, start low, lsb first
// (R21) register write: select word then data word
module lss_sensor_dev
  import lss_pkg::*;
(
  // link to the controller
  lss_link_if.dev         link,
  // integrator control towards the array
  output logic            integ_clear,
  output logic            integ_run,
  output logic            sample_strobe,
  // converter access for the pixel being read
  output logic [6:0]      pix_index,
  input  wire logic [7:0] pix_raw,
  // status
  output logic            readout_busy,
  output logic [3:0]      test_mode,
  output logic            cmd_frame_err
);
  import lss_pkg::*;

  // link reset brought into the link clock domain
  logic rst_meta_reg;  // first stage, read only by the second
  logic rst_sync_reg;  // synchronised link reset, active low
  wire  rst_n = rst_sync_reg;

  // received words
  logic       rx_valid;  // one cycle per good word
  logic [7:0] rx_word;   // word value
  logic       rx_err;    // framing error pulse

  // register write sequencing
  logic       wr_pend_reg;  // next word is register data
  logic [4:0] wr_addr_reg;  // selected register

  // zone and mode registers
  logic [7:0] ofs_reg  [ZONES];  // offset code per zone
  logic [4:0] gain_reg [ZONES];  // gain code per zone
  logic [3:0] mode_reg;          // test and cascade options

  // integrator state
  logic clear_reg;   // integrators held at zero
  logic run_reg;     // integration period open
  logic strobe_reg;  // sample and hold pulse
  logic err_reg;     // framing error pulse

  // readout sequencer
  lss_ser_e   rd_state_reg;  // slot of the current pixel word
  logic [6:0] pix_reg;       // pixel being sent
  logic [2:0] bit_reg;       // data bit index
  logic [7:0] shift_reg;     // code being shifted out
  logic       tx_bit_reg;    // bit chosen on the rising edge
  logic       serial_pixel_out_reg;     // pin level, moved on the falling edge

  // two flops on the reset pin before anything reads it
  always_ff @(posedge link.sclk) begin
    rst_meta_reg <= link.link_rst_n;
    rst_sync_reg <= rst_meta_reg;
  end

  // word receiver on the rising link clock edge
  lss_frame_rx u_rx (
    .clk        (link.sclk),
    .rst_n      (rst_n),
    .line       (link.serial_command_in),
    .word_valid (rx_valid),
    .word       (rx_word),
    .frame_err  (rx_err)
  );

  // command decode; the word after a write select is always data
  wire cmd_ok      = rx_valid & ~wr_pend_reg;
  wire is_wr_sel   = (rx_word & CMD_WR_MASK) == CMD_WR_BASE;  // R21
  wire do_wr_sel   = cmd_ok & is_wr_sel;
  wire do_wr_data  = rx_valid & wr_pend_reg;  // R21
  wire do_reset    = cmd_ok & (rx_word == CMD_RESET);
  wire do_begin    = cmd_ok & (rx_word == CMD_BEGIN);
  wire do_capture  = cmd_ok & (rx_word == CMD_CAPTURE);
  wire do_read     = cmd_ok & (rx_word == CMD_READOUT);
  wire do_cancel   = cmd_ok & (rx_word == CMD_CANCEL);
  wire do_stop     = do_cancel | do_reset;  // R01

  // register address decode: even address offset, odd gain
  wire [1:0] wr_zone  = wr_addr_reg[2:1];
  wire       wr_gain  = wr_addr_reg[0];
  wire       wr_zoned = wr_addr_reg <= ADDR_Z2_GAIN;  // R17
  wire       wr_mode  = wr_addr_reg == ADDR_MODE;

  // correction of the pixel now addressed, using its own zone
  wire [1:0] cur_zone = zone_of(pix_reg);  // R02
  wire [7:0] pix_code = corrected(pix_raw, ofs_reg[cur_zone],
                                  gain_reg[cur_zone]);  // R04

  // write select remembers the address; a framing error drops it
  always_ff @(posedge link.sclk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= ADDR_Z0_OFS;
    end else if (rx_err) begin
      wr_pend_reg <= 1'b0;
    end else if (do_wr_sel) begin
      wr_pend_reg <= 1'b1;
      wr_addr_reg <= rx_word[4:0];
    end else if (do_wr_data) begin
      wr_pend_reg <= 1'b0;
    end
  end

  // zone registers; unmapped addresses take the data and drop it
  always_ff @(posedge link.sclk) begin
    if (!rst_n) begin
      for (int z = 0; z < ZONES; z++) begin
        ofs_reg[z]  <= OFS_RST;
        gain_reg[z] <= GAIN_RST;
      end
    end else if (do_wr_data && wr_zoned) begin
      if (wr_gain)
        gain_reg[wr_zone] <= rx_word[4:0];  // R18
      else
        ofs_reg[wr_zone] <= rx_word;  // R17
    end
  end

  // mode register keeps whatever is written, only its low four bits
  always_ff @(posedge link.sclk) begin
    if (!rst_n)
      mode_reg <= MODE_RST;
    else if (do_wr_data && wr_mode)
      mode_reg <= rx_word[3:0];
  end

  // integrators: one shared clear, one period and one strobe for all
  // pixels, so no pixel sees a different window
  always_ff @(posedge link.sclk) begin
    if (!rst_n) begin
      clear_reg  <= 1'b1;
      run_reg    <= 1'b0;
      strobe_reg <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      err_reg    <= rx_err;
      strobe_reg <= do_capture & run_reg;  // R13 R16
      if (do_reset) begin
        clear_reg <= 1'b1;  // R11
        run_reg   <= 1'b0;
      end else if (do_begin) begin
        clear_reg <= 1'b0;  // R12
        run_reg   <= 1'b1;  // R16
      end else if (do_capture) begin
        run_reg   <= 1'b0;  // R13
      end
    end
  end

  // readout: ten slots per pixel; a new readout restarts at pixel 0
  always_ff @(posedge link.sclk) begin
    if (!rst_n) begin
      rd_state_reg <= SER_IDLE;
      pix_reg      <= PIX_FIRST;
      bit_reg      <= BIT_FIRST;
      shift_reg    <= CODE_MIN;
      tx_bit_reg   <= LINE_IDLE;
    end else if (do_stop) begin
      rd_state_reg <= SER_IDLE;  // R01
      tx_bit_reg   <= LINE_IDLE;
    end else if (do_read) begin
      rd_state_reg <= SER_START;
      pix_reg      <= PIX_FIRST;
      tx_bit_reg   <= LINE_IDLE;
    end else begin
      unique case (rd_state_reg)
        SER_IDLE: begin
          tx_bit_reg <= LINE_IDLE;  // R20
        end
        SER_START: begin
          tx_bit_reg   <= LINE_START;  // R08
          shift_reg    <= pix_code;  // R14
          bit_reg      <= BIT_FIRST;
          rd_state_reg <= SER_DATA;
        end
        SER_DATA: begin
          tx_bit_reg <= shift_reg[0];  // R20
          shift_reg  <= {1'b0, shift_reg[7:1]};
          bit_reg    <= bit_reg + 3'h1;
          if (bit_reg == BIT_LAST)
            rd_state_reg <= SER_STOP;
        end
        SER_STOP: begin
          tx_bit_reg <= LINE_IDLE;  // R08
          if (pix_reg == PIX_LAST) begin
            rd_state_reg <= SER_IDLE;  // R01
          end else begin
            pix_reg      <= pix_reg + 7'h01;  // R01
            rd_state_reg <= SER_START;
          end
        end
      endcase
    end
  end

  // pin moves half a period after the choice, so the controller has
  // a full half period of setup before its next rising edge
  always_ff @(negedge link.sclk) begin
    if (!rst_n)
      serial_pixel_out_reg <= LINE_IDLE;
    else
      serial_pixel_out_reg <= tx_bit_reg;  // R10
  end

  // outputs
  assign link.serial_pixel_out = serial_pixel_out_reg;
  assign integ_clear   = clear_reg;
  assign integ_run     = run_reg;
  assign sample_strobe = strobe_reg;
  assign pix_index     = pix_reg;
  assign readout_busy  = rd_state_reg != SER_IDLE;
  assign test_mode     = mode_reg;
  assign cmd_frame_err = err_reg;
endmodule

/* File: verilog/lss_ctl_host.sv */
// controller end: link clock divider, word sender and pixel receiver
`timescale 1ns/1ps
module lss_ctl_host
  import lss_pkg::*;
(
  // system clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // link to the sensor
  lss_link_if.ctl         link,
  // outgoing command and data words
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [7:0] cmd_word,
  // incoming pixel codes
  output logic            pix_valid,
  output logic [7:0]      pix_data,
  output logic            pix_frame_err,
  // link state
  output logic            link_up
);
  import lss_pkg::*;

  // clock divider and link reset
  logic [1:0] ph_reg;      // phase within one link clock
  logic       sclk_reg;    // link clock pin
  logic [2:0] lrst_reg;    // link clocks since own reset
  logic       lrst_n_reg;  // link reset pin
  logic       up_reg;      // sensor out of reset

  // sender
  lss_ser_e   tx_state_reg;  // slot of the word on the line
  logic [2:0] tx_bit_reg;    // data bit index
  logic [7:0] tx_shift_reg;  // word being sent
  logic       serial_command_in_reg;      // command pin
  logic       wr_next_reg;   // next accepted word is register data
  logic       mode_sel_reg;  // that data goes to the mode register

  // receiver
  logic       so_meta_reg;   // first stage, read only by the second
  logic       so_sync_reg;   // synchronised sensor output
  lss_ser_e   rx_state_reg;  // receiver state
  logic [2:0] rx_bit_reg;    // data bit index
  logic [7:0] rx_shift_reg;  // assembling code
  logic [7:0] data_reg;      // last good code
  logic       valid_reg;     // one cycle code pulse
  logic       ferr_reg;      // one cycle framing error pulse

  // divider events; the 25 MHz clock over four gives 6.25 MHz, below
  // the 10 MHz ceiling of the link
  wire rise_ev = ph_reg == PH_RISE;
  wire fall_ev = ph_reg == PH_FALL;
  wire samp_ev = (ph_reg == PH_SAMP) & up_reg;
  wire accept  = cmd_valid & cmd_ready;  // R15
  wire sel_wd  = (cmd_word & CMD_WR_MASK) == CMD_WR_BASE;
  wire to_mode = wr_next_reg & mode_sel_reg;  // R19

  // link clock made here, so no second domain on this side
  always_ff @(posedge sys_clk) begin  // R07
    if (!rstn) begin
      ph_reg   <= PH_SAMP;
      sclk_reg <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      if (rise_ev)
        sclk_reg <= 1'b1;
      else if (fall_ev)
        sclk_reg <= 1'b0;
    end
  end

  // sensor is held in reset for some link clocks, then given time to
  // pass its two flop synchroniser before any word goes out
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lrst_reg   <= 3'h0;
      lrst_n_reg <= 1'b0;
      up_reg     <= 1'b0;
    end else if (fall_ev && !up_reg) begin
      lrst_reg <= lrst_reg + 3'h1;
      if (lrst_reg == LRST_RELEASE)
        lrst_n_reg <= 1'b1;
      if (lrst_reg == LRST_UP)
        up_reg <= 1'b1;
    end
  end

  // word order is exactly the order offered; the user keeps the
  // acquisition order and programs offsets before gains
  always_ff @(posedge sys_clk) begin  // R15 R06
    if (!rstn) begin
      wr_next_reg  <= 1'b0;
      mode_sel_reg <= 1'b0;
    end else if (accept) begin
      wr_next_reg  <= ~wr_next_reg & sel_wd;  // R21
      mode_sel_reg <= cmd_word[4:0] == ADDR_MODE;
    end
  end

  // sender: line changes only as the link clock falls, so each bit is
  // steady across the sensor's rising edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_state_reg <= SER_IDLE;
      tx_bit_reg   <= BIT_FIRST;
      tx_shift_reg <= CODE_MIN;
      serial_command_in_reg     <= LINE_IDLE;
    end else if (accept) begin
      tx_state_reg <= SER_START;
      tx_shift_reg <= to_mode ? {4'h0, MODE_RST} : cmd_word;  // R19
    end else if (fall_ev) begin  // R09
      unique case (tx_state_reg)
        SER_IDLE: begin
          serial_command_in_reg <= LINE_IDLE;  // R20
        end
        SER_START: begin
          serial_command_in_reg     <= LINE_START;  // R08
          tx_bit_reg   <= BIT_FIRST;
          tx_state_reg <= SER_DATA;
        end
        SER_DATA: begin
          serial_command_in_reg     <= tx_shift_reg[0];  // R20
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bit_reg   <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == BIT_LAST)
            tx_state_reg <= SER_STOP;
        end
        SER_STOP: begin
          serial_command_in_reg     <= LINE_IDLE;  // R08
          tx_state_reg <= SER_IDLE;
        end
      endcase
    end
  end

  // two flops on the sensor output pin
  always_ff @(posedge sys_clk) begin
    so_meta_reg <= link.serial_pixel_out;
    so_sync_reg <= so_meta_reg;
  end

  // receiver: the synchronised bit settles by the rising edge after
  // the sensor's falling edge and is taken one system clock later
  always_ff @(posedge sys_clk) begin  // R10
    if (!rstn) begin
      rx_state_reg <= SER_IDLE;
      rx_bit_reg   <= BIT_FIRST;
      rx_shift_reg <= CODE_MIN;
      data_reg     <= CODE_MIN;
      valid_reg    <= 1'b0;
      ferr_reg     <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      ferr_reg  <= 1'b0;
      if (samp_ev) begin
        unique case (rx_state_reg)
          SER_IDLE, SER_START: begin
            if (so_sync_reg == LINE_START) begin  // R20
              rx_state_reg <= SER_DATA;
              rx_bit_reg   <= BIT_FIRST;
            end
          end
          SER_DATA: begin
            rx_shift_reg <= {so_sync_reg, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == BIT_LAST)
              rx_state_reg <= SER_STOP;
          end
          SER_STOP: begin
            rx_state_reg <= SER_IDLE;
            if (so_sync_reg == LINE_IDLE) begin  // R08
              data_reg  <= rx_shift_reg;
              valid_reg <= 1'b1;
            end else begin
              ferr_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // outputs
  assign link.sclk              = sclk_reg;
  assign link.serial_command_in = serial_command_in_reg;
  assign link.link_rst_n        = lrst_n_reg;
  assign cmd_ready     = up_reg & (tx_state_reg == SER_IDLE);
  assign pix_valid     = valid_reg;
  assign pix_data      = data_reg;
  assign pix_frame_err = ferr_reg;
  assign link_up       = up_reg;
endmodule

/* File: dv/lss_link_sva.sv */
// link wire checker: framing, clock edges, pixel bursts
`timescale 1ns/1ps
module lss_link_sva (
  // link wires
  input wire logic sclk,
  input wire logic serial_command_in,
  input wire logic serial_pixel_out,
  input wire logic link_rst_n
);
  logic [3:0] cc_reg, cc_next;  // samples into a command word
  logic [3:0] pc_reg, pc_next;  // samples into a pixel word
  logic [6:0] wc_reg, wc_next;  // pixel words in this burst
  logic [3:0] sc_reg, sc_next;  // rises since a command stop
  logic       ci_reg, po_reg;   // line levels at last rise
  default clocking @(posedge sclk); endclocking
  default disable iff (!link_rst_n);
  // a low sample while idle opens a ten bit frame
  assign cc_next = (cc_reg == 4'h9) ? 4'h0 :
    (cc_reg != 4'h0 || !serial_command_in) ? cc_reg + 4'h1 : 4'h0;
  assign pc_next = (pc_reg == 4'h9) ? 4'h0 :
    (pc_reg != 4'h0 || !serial_pixel_out) ? pc_reg + 4'h1 : 4'h0;
  // an idle sample ends a burst
  assign wc_next = (pc_reg == 4'h0 && serial_pixel_out) ? 7'h00 :
    wc_reg + {6'h00, pc_reg == 4'h9};
  // saturates so a quiet link never wraps back into range
  assign sc_next = (cc_reg == 4'h9) ? 4'h0 : sc_reg + {3'h0, sc_reg != 4'hF};
  // helper state restarts with the link
  always_ff @(posedge sclk) begin
    ci_reg <= serial_command_in;
    po_reg <= serial_pixel_out;
    cc_reg <= link_rst_n ? cc_next : 4'h0;
    pc_reg <= link_rst_n ? pc_next : 4'h0;
    wc_reg <= link_rst_n ? wc_next : 7'h00;
    sc_reg <= link_rst_n ? sc_next : 4'hF;
  end
  cmd_hold_a: assert property (@(negedge sclk) disable iff (!link_rst_n)
    serial_command_in == ci_reg) else $error("command bit moved at rise");
  pix_hold_a: assert property (@(negedge sclk) disable iff (!link_rst_n)
    serial_pixel_out == po_reg) else $error("pixel bit moved at rise");
  cmd_frame_a: assert property (
    cc_reg == 4'h0 && !serial_command_in |-> ##9 serial_command_in)
    else $error("command stop bit low");
  pix_stop_a: assert property (pc_reg == 4'h9 |-> serial_pixel_out)
    else $error("pixel stop bit low");
  cmd_idle_a: assert property (
    $rose(link_rst_n) |-> serial_command_in [*3]) else $error("cmd not idle");
  pix_idle_a: assert property (
    $rose(link_rst_n) |-> serial_pixel_out [*2]) else $error("pix not idle");
  pix_burst_a: assert property (pc_reg == 4'h9 |-> wc_reg < 7'h66)
    else $error("burst longer than array");
  pix_start_a: assert property (
    pc_reg == 4'h0 && wc_reg == 7'h00 && !serial_pixel_out |->
    sc_reg inside {[4'h1:4'h8]}) else $error("burst without command");
  cover property (pc_reg == 4'h9 && wc_reg == 7'h65);
  cover property (cc_reg == 4'h9);
  cover property ($rose(link_rst_n));
endmodule

/* File: dv/test_linear_sensor_serial_control.sv */
// bench: host and sensor joined over the link
`timescale 1ns/1ps
module test_linear_sensor_serial_control;
  import lss_pkg::*;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  logic       sys_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0;
  logic       cmd_ready, pix_valid, link_up, clr, run, stb, busy;
  logic       stb_seen = 1'b0;  // sticky: strobe seen on a link clock rise
  logic       cfe, pfe;         // frame error pulses of both receivers
  logic       ferr_seen = 1'b0; // sticky: a frame error in either way
  logic [7:0] cmd_word = 8'h00, pix_data, pix_raw;
  logic [6:0] pix_index;
  logic [3:0] test_mode;
  int         failures = 0, compares = 0;
  logic [7:0] ofs [3] = '{8'h05, 8'h85, 8'hFF};  // plus, minus, most minus
  logic [4:0] gn [3] = '{5'h00, 5'h1F, 5'h0A};
  lss_link_if link ();
  always #20 sys_clk = ~sys_clk;
  // raw light ramps with position so zone borders show
  assign pix_raw = {pix_index, 1'b1};
  always @(posedge link.sclk) if (stb === 1'b1) stb_seen <= 1'b1;
  // sensor pulse lasts four system clocks, so one sampler sees both
  always @(posedge sys_clk) if (pfe === 1'b1 || cfe === 1'b1)
    ferr_seen <= 1'b1;
  lss_sensor_dev u_lss_sensor_dev (.link(link), .integ_clear(clr),
    .integ_run(run), .sample_strobe(stb), .pix_index(pix_index),
    .pix_raw(pix_raw), .readout_busy(busy), .test_mode(test_mode),
    .cmd_frame_err(cfe));
  lss_ctl_host u_lss_ctl_host (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_frame_err(pfe),
    .link_up(link_up));
  lss_link_sva u_lss_link_sva (.sclk(link.sclk), .link_rst_n(link.link_rst_n),
    .serial_command_in(link.serial_command_in),
    .serial_pixel_out(link.serial_pixel_out));
  task automatic end_of_test;
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // offer a word, hold until taken, then let it reach the sensor
  task automatic send(input logic [7:0] w);
    int n;
    @(posedge sys_clk);
    cmd_word <= w;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    `CHK("cmd_ready", 1'b1, cmd_ready)
    cmd_valid <= 1'b0;
    repeat (52) @(posedge sys_clk);
  endtask
  // expected code: signed offset first, then gain, then clamp
  function automatic logic [7:0] want(input int i);
    int z, s;
    z = (i < 34) ? 0 : (i < 68) ? 1 : 2;
    s = 2 * i + 1 + (ofs[z][7] ? -int'(ofs[z][6:0]) : int'(ofs[z][6:0]));
    s = (s * int'(GAIN_Q8[gn[z]])) >>> 8;
    return (s < 0) ? 8'h00 : (s > 255) ? 8'hFF : s[7:0];
  endfunction
  task automatic readout(input int last);
    int n;
    send(CMD_READOUT);
    for (int i = 0; i <= last; i++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (pix_valid !== 1'b1 && n < 100);
      `CHK("pix_valid", 1'b1, pix_valid)
      `CHK("pixel", want(i), pix_data)
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    wait (link_up === 1'b1);
    for (int z = 0; z < 3; z++) begin
      send(CMD_WR_BASE | 8'(2 * z));
      send(ofs[z]);
      send(CMD_WR_BASE | 8'(2 * z + 1));
      send({3'h0, gn[z]});
    end
    send(CMD_WR_BASE | {3'h0, ADDR_MODE});
    send(8'h0F);
    `CHK("mode", 4'h0, test_mode)
    send(CMD_RESET);
    `CHK("clear", 2'b10, {clr, run})
    send(CMD_BEGIN);
    `CHK("begin", 2'b01, {clr, run})
    send(CMD_CAPTURE);
    `CHK("capture", 3'b001, {clr, run, stb_seen})
    readout(101);
    repeat (8) @(posedge sys_clk);
    `CHK("done", 1'b0, busy)
    readout(4);
    send(CMD_CANCEL);
    `CHK("cancel", 1'b0, busy)
    readout(4);
    send(CMD_RESET);
    `CHK("reset", 2'b10, {clr, busy})
    `CHK("frame err", 1'b0, ferr_seen)
    end_of_test();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
endmodule
